// File: aic_regs.sv
// converter register block: avalon slave, sequencing, accumulation, flags
//
// Chosen here: the Avalon-MM interface to the registers.
`timescale 1ns/10ps

// Overview of operation
// - event input starts a conversion only while event trigger enable is set
// - interrupt enable bit 1 gates the window match interrupt
// - interrupt enable bit 0 gates the conversion done interrupt
// - at measurement end, flag bit 1 set only if window condition holds
// - window flag clears on write one or result read; zero write ignored
// - flag bit 0 set whenever a measurement finishes with fresh result
// - done flag clears on write one or result read; zero write ignored
// - halted cpu freezes converter and drops events unless keep-running is set
// - one shared staging byte serves all 16-bit registers, directly readable and writable
// - 16-bit result low byte at base index, high byte at base plus one
// - each 10-bit sample saturates to 0x3ff above reference, zero below ground
// - at most 64 samples accumulate, sum never exceeds 0xffc0
// - core gives 12-bit signed reading, saturated to a 10-bit sample, stored as single or accumulated value
// - result unsigned, read-only, resets to zero
// - window mode: none, below, above, strictly inside, outside; others reserved
// - begin conversion bit reads one while busy, clears itself at completion
// - window comparison uses the final accumulated sum, not each sample
module aic_regs
   import aic_pkg::*;
(
   input wire logic clk,
   input wire logic srst,
   input wire logic [7:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   input wire logic [3:0] avs_byteenable,
   output logic [31:0] avs_readdata,
   output logic avs_waitrequest,
   input wire logic event_in,
   input wire logic cpu_halted,
   input wire aic_sample_t core_sample,
   output logic core_start,
   output logic core_enable,
   output logic irq
);

   typedef enum logic [1:0] {
      AIC_IDLE = 2'b00,
      AIC_START = 2'b01,
      AIC_WAIT = 2'b11,
      AIC_FINISH = 2'b10
   } aic_state_t;

   aic_state_t state;
   aic_state_t next_state;
   logic resp;
   logic [5:0] index;
   logic acc_wr;
   logic acc_rd;
   logic wr_lo;
   logic [7:0] wbyte;
   logic [31:0] next_readdata;

   logic [2:0] accum_sel;
   logic [2:0] window_mode_select;
   logic event_trigger_enable;
   aic_irq_t interrupt_enable;
   aic_irq_t interrupt_flags;
   logic keep_running_when_halted;
   logic [7:0] staging;
   logic [15:0] conversion_output;
   logic [15:0] lower_threshold;
   logic [15:0] upper_threshold;

   logic start_req;
   logic frozen;
   logic [15:0] acc_sum;
   logic [6:0] sample_count;
   logic [6:0] sample_target;
   logic [9:0] sample_sat;
   logic window_hit;
   aic_irq_t flag_set;
   aic_irq_t flag_clr;
   logic result_read;
   logic last_sample;
   logic cmd_start;
   logic event_start;

   // clamp a raw reading into the 10-bit unsigned range
   function automatic logic [9:0] saturate(input logic signed [11:0] raw);
      logic [9:0] r;
      r = SAMPLE_MIN;
      if (raw > $signed({2'b00, SAMPLE_MAX})) begin
         r = SAMPLE_MAX;
      end else if (raw < 12'sh000) begin
         r = SAMPLE_MIN;
      end else begin
         r = raw[9:0];
      end
      return r;
   endfunction

   // write strobe for one register word
   function automatic logic write_to(input logic strobe, input logic [5:0] at, input logic [5:0] want);
      return strobe && (at == want);
   endfunction

   // ---------------- avalon slave ----------------
   // every access takes one wait cycle so read data can come from flops
   assign index = avs_address[7:2];
   assign avs_waitrequest = (avs_read || avs_write) && !resp;
   assign acc_wr = avs_write && resp;
   assign acc_rd = avs_read && resp;
   assign wr_lo = acc_wr && avs_byteenable[0];
   assign wbyte = avs_writedata[7:0];

   always_ff @(posedge clk) begin
      if (srst) begin
         resp <= 1'b0;
      end else begin
         resp <= (avs_read || avs_write) && !resp;
      end
   end

   always_comb begin
      next_readdata = 32'h0000_0000;
      unique case (index)
         IDX_ACCUM_CTRL: next_readdata[2:0] = accum_sel;
         IDX_WIN_MODE: next_readdata[2:0] = window_mode_select;
         IDX_COMMAND: next_readdata[BIT_BEGIN] = start_req || (state != AIC_IDLE);
         IDX_EVENT_CTRL: next_readdata[BIT_EVENT_EN] = event_trigger_enable;
         IDX_IRQ_ENABLE: next_readdata[1:0] = interrupt_enable;
         IDX_IRQ_FLAGS: next_readdata[1:0] = interrupt_flags;
         IDX_DEBUG_CTRL: next_readdata[BIT_KEEP_RUN] = keep_running_when_halted;
         IDX_STAGING: next_readdata[7:0] = staging;
         IDX_RESULT_LO: next_readdata[7:0] = conversion_output[7:0];
         IDX_RESULT_HI: next_readdata[7:0] = staging;
         IDX_LOWER_LO: next_readdata[7:0] = lower_threshold[7:0];
         IDX_LOWER_HI: next_readdata[7:0] = staging;
         IDX_UPPER_LO: next_readdata[7:0] = upper_threshold[7:0];
         IDX_UPPER_HI: next_readdata[7:0] = staging;
         // clear register is write-only; unmapped words read zero
         default: next_readdata = 32'h0000_0000;
      endcase
   end

   // loaded while the request waits, so it stands at the completing edge
   always_ff @(posedge clk) begin
      if (srst) begin
         avs_readdata <= 32'h0000_0000;
      end else if (avs_read && !resp) begin
         avs_readdata <= next_readdata;
      end
   end

   // ---------------- plain control registers ----------------
   always_ff @(posedge clk) begin
      if (srst) begin
         accum_sel <= 3'h0;
      end else if (write_to(wr_lo, index, IDX_ACCUM_CTRL)) begin
         accum_sel <= wbyte[ACC_SEL_LSB +: ACC_SEL_W];
      end
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         window_mode_select <= 3'h0;
      end else if (write_to(wr_lo, index, IDX_WIN_MODE)) begin
         window_mode_select <= wbyte[WIN_MODE_W-1:0];
      end
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         event_trigger_enable <= 1'b0;
      end else if (write_to(wr_lo, index, IDX_EVENT_CTRL)) begin
         event_trigger_enable <= wbyte[BIT_EVENT_EN];
      end
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         interrupt_enable <= FLAGS_RESET;
      end else if (write_to(wr_lo, index, IDX_IRQ_ENABLE)) begin
         interrupt_enable <= wbyte[1:0];
      end
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         keep_running_when_halted <= 1'b0;
      end else if (write_to(wr_lo, index, IDX_DEBUG_CTRL)) begin
         keep_running_when_halted <= wbyte[BIT_KEEP_RUN];
      end
   end

   // ---------------- shared staging byte and 16-bit pairs ----------------
   // low byte read latches the high byte; low byte write parks data until
   // the high byte write commits the whole word in one edge
   always_ff @(posedge clk) begin
      if (srst) begin
         staging <= BYTE_RESET;
      end else if (acc_wr && avs_byteenable[0] &&
                   (index == IDX_STAGING || index == IDX_LOWER_LO || index == IDX_UPPER_LO)) begin
         staging <= wbyte;
      end else if (acc_rd) begin
         unique case (index)
            IDX_RESULT_LO: staging <= conversion_output[15:8];
            IDX_LOWER_LO: staging <= lower_threshold[15:8];
            IDX_UPPER_LO: staging <= upper_threshold[15:8];
            default: ;
         endcase
      end
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         lower_threshold <= WORD_RESET;
      end else if (write_to(wr_lo, index, IDX_LOWER_HI)) begin
         lower_threshold <= {wbyte, staging};
      end
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         upper_threshold <= WORD_RESET;
      end else if (write_to(wr_lo, index, IDX_UPPER_HI)) begin
         upper_threshold <= {wbyte, staging};
      end
   end

   // ---------------- conversion sequencing ----------------
   assign frozen = cpu_halted && !keep_running_when_halted;
   assign core_enable = !frozen;
   assign core_start = (state == AIC_START) && !frozen;
   assign sample_sat = saturate(core_sample.raw);
   // selections beyond 64 samples are held at 64 so the sum fits
   assign sample_target = 7'h01 << ((accum_sel > ACC_LOG2_MAX) ? ACC_LOG2_MAX : accum_sel);
   assign last_sample = (sample_count + 7'h01) == sample_target;
   assign cmd_start = write_to(wr_lo, index, IDX_COMMAND) && wbyte[BIT_BEGIN];
   // events are dropped, not queued, while frozen
   assign event_start = event_in && event_trigger_enable && !frozen;

   always_ff @(posedge clk) begin
      if (srst) begin
         start_req <= 1'b0;
      end else if (state == AIC_IDLE && start_req && !frozen) begin
         // a request landing in the launch cycle merges into that conversion
         start_req <= 1'b0;
      end else if (cmd_start || event_start) begin
         start_req <= 1'b1;
      end
   end

   always_comb begin
      next_state = state;
      unique case (state)
         AIC_IDLE: if (start_req) begin
            next_state = AIC_START;
         end
         AIC_START: next_state = AIC_WAIT;
         AIC_WAIT: if (core_sample.valid) begin
            next_state = last_sample ? AIC_FINISH : AIC_START;
         end
         AIC_FINISH: next_state = AIC_IDLE;
      endcase
   end

   // freeze holds the sequencer, so samples arriving meanwhile are lost
   always_ff @(posedge clk) begin
      if (srst) begin
         state <= AIC_IDLE;
      end else if (!frozen) begin
         state <= next_state;
      end
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         acc_sum <= WORD_RESET;
      end else if (!frozen) begin
         if (state == AIC_IDLE) begin
            acc_sum <= WORD_RESET;
         end else if (state == AIC_WAIT && core_sample.valid) begin
            acc_sum <= acc_sum + {6'h00, sample_sat};
         end
      end
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         sample_count <= 7'h00;
      end else if (!frozen) begin
         if (state == AIC_IDLE) begin
            sample_count <= 7'h00;
         end else if (state == AIC_WAIT && core_sample.valid) begin
            sample_count <= sample_count + 7'h01;
         end
      end
   end

   // result moves only at finish; the staging latch keeps a pair read whole
   always_ff @(posedge clk) begin
      if (srst) begin
         conversion_output <= WORD_RESET;
      end else if (state == AIC_FINISH && !frozen) begin
         conversion_output <= acc_sum;
      end
   end

   aic_window u_window (
      .window_mode_select(window_mode_select),
      .value(acc_sum),
      .lower_threshold(lower_threshold),
      .upper_threshold(upper_threshold),
      .window_match(window_hit)
   );

   // ---------------- interrupt flags ----------------
   // either byte of the result clears both flags
   assign result_read = acc_rd && (index == IDX_RESULT_LO || index == IDX_RESULT_HI);

   always_comb begin
      flag_set.conversion_done = (state == AIC_FINISH) && !frozen;
      flag_set.window_match = (state == AIC_FINISH) && !frozen && window_hit;
      flag_clr = FLAGS_RESET;
      if (acc_wr && avs_byteenable[0] && (index == IDX_IRQ_FLAGS || index == IDX_IRQ_CLEAR)) begin
         flag_clr = wbyte[1:0];
      end
      if (result_read) begin
         flag_clr = 2'h3;
      end
   end

   // a set in the same cycle as a clear keeps the flag
   always_ff @(posedge clk) begin
      if (srst) begin
         interrupt_flags <= FLAGS_RESET;
      end else begin
         interrupt_flags <= (interrupt_flags & ~flag_clr) | flag_set;
      end
   end

   assign irq = |(interrupt_flags & interrupt_enable);

endmodule // aic_regs

// File: aic_pkg.sv
// shared constants, register map and types for the converter register block
package aic_pkg;

   // register word indices; byte address is four times the index
   localparam logic [5:0] IDX_ACCUM_CTRL = 6'h01;
   localparam logic [5:0] IDX_WIN_MODE = 6'h04;
   localparam logic [5:0] IDX_COMMAND = 6'h08;
   localparam logic [5:0] IDX_EVENT_CTRL = 6'h09;
   localparam logic [5:0] IDX_IRQ_ENABLE = 6'h0a;
   localparam logic [5:0] IDX_IRQ_FLAGS = 6'h0b;
   localparam logic [5:0] IDX_DEBUG_CTRL = 6'h0c;
   localparam logic [5:0] IDX_STAGING = 6'h0d;
   localparam logic [5:0] IDX_IRQ_CLEAR = 6'h0e;
   localparam logic [5:0] IDX_RESULT_LO = 6'h10;
   localparam logic [5:0] IDX_RESULT_HI = 6'h11;
   localparam logic [5:0] IDX_LOWER_LO = 6'h12;
   localparam logic [5:0] IDX_LOWER_HI = 6'h13;
   localparam logic [5:0] IDX_UPPER_LO = 6'h14;
   localparam logic [5:0] IDX_UPPER_HI = 6'h15;

   // field positions
   localparam int unsigned BIT_DONE = 0;
   localparam int unsigned BIT_WINDOW = 1;
   localparam int unsigned BIT_BEGIN = 0;
   localparam int unsigned BIT_EVENT_EN = 0;
   localparam int unsigned BIT_KEEP_RUN = 0;
   localparam int unsigned ACC_SEL_LSB = 0;
   localparam int unsigned ACC_SEL_W = 3;
   localparam int unsigned WIN_MODE_W = 3;

   // reset values and limits
   localparam logic [7:0] BYTE_RESET = 8'h00;
   localparam logic [15:0] WORD_RESET = 16'h0000;
   localparam logic [1:0] FLAGS_RESET = 2'h0;
   localparam logic [9:0] SAMPLE_MAX = 10'h3ff;
   localparam logic [9:0] SAMPLE_MIN = 10'h000;
   localparam logic [2:0] ACC_LOG2_MAX = 3'h6;

   typedef enum logic [2:0] {
      AIC_WIN_NONE = 3'h0,
      AIC_WIN_BELOW = 3'h1,
      AIC_WIN_ABOVE = 3'h2,
      AIC_WIN_INSIDE = 3'h3,
      AIC_WIN_OUTSIDE = 3'h4
   } aic_win_mode_t;

   // raw reading from the analog core, before saturation
   typedef struct packed {
      logic valid;
      logic signed [11:0] raw;
   } aic_sample_t;

   // interrupt sources, same layout in flags, enable and clear
   typedef struct packed {
      logic window_match;
      logic conversion_done;
   } aic_irq_t;

endpackage

// File: aic_window.sv
// window comparator on the final result
`timescale 1ns/10ps
module aic_window
   import aic_pkg::*;
(
   input wire logic [2:0] window_mode_select,
   input wire logic [15:0] value,
   input wire logic [15:0] lower_threshold,
   input wire logic [15:0] upper_threshold,
   output logic window_match
);

   logic below;
   logic above;

   assign below = value < lower_threshold;
   assign above = value > upper_threshold;

   always_comb begin
      window_match = 1'b0;
      unique case (window_mode_select)
         AIC_WIN_NONE: window_match = 1'b0;
         AIC_WIN_BELOW: window_match = below;
         AIC_WIN_ABOVE: window_match = above;
         AIC_WIN_INSIDE: window_match = (value > lower_threshold) && (value < upper_threshold);
         AIC_WIN_OUTSIDE: window_match = below || above;
         // reserved codes never flag
         default: window_match = 1'b0;
      endcase
   end

endmodule // aic_window

// File: aic_regs_assertions.sv
// port-level checker for the converter register block, with its bind
`timescale 1ns/10ps
module aic_regs_chk
   import aic_pkg::*;
(
   input wire logic clk,
   input wire logic srst,
   input wire logic [7:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   input wire logic [3:0] avs_byteenable,
   input wire logic [31:0] avs_readdata,
   input wire logic avs_waitrequest,
   input wire logic event_in,
   input wire logic cpu_halted,
   input wire aic_sample_t core_sample,
   input wire logic core_start,
   input wire logic core_enable,
   input wire logic irq
);
   logic wr_ok;
   logic [1:0] en_q;
   logic keep_q;
   assign wr_ok = avs_write && !avs_waitrequest && avs_byteenable[0];
   // enable mirrors follow completed writes, so irq and freeze are judged without internals
   always_ff @(posedge clk) begin
      if (srst) begin
         en_q <= 2'h0;
         keep_q <= 1'b0;
      end else if (wr_ok && avs_address[7:2] == IDX_IRQ_ENABLE) begin
         en_q <= avs_writedata[1:0];
      end else if (wr_ok && avs_address[7:2] == IDX_DEBUG_CTRL) begin
         keep_q <= avs_writedata[0];
      end
   end
   default clocking cb @(posedge clk); endclocking
   default disable iff (srst);
   // a finish in the clearing cycle would win, so no sample may precede it
   sequence s_clr_all;
      !core_sample.valid ##1 (wr_ok && (avs_address[7:2] == IDX_IRQ_FLAGS || avs_address[7:2] == IDX_IRQ_CLEAR)
         && avs_writedata[1:0] == 2'h3 && !core_sample.valid);
   endsequence
   sequence s_res_read;
      !core_sample.valid ##1 (avs_read && !avs_waitrequest && avs_address[7:3] == 5'h08 && !core_sample.valid);
   endsequence
   a_one_wait: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
      else $error("access not answered after one wait cycle");
   a_run_free: assert property (!cpu_halted |-> core_enable)
      else $error("core disabled while cpu running");
   a_halt_freeze: assert property (cpu_halted && !keep_q |-> !core_enable)
      else $error("core enabled while halted without keep running");
   a_halt_keep: assert property (keep_q |-> core_enable)
      else $error("core stopped although keep running set");
   a_frozen_quiet: assert property (!core_enable |-> !core_start)
      else $error("core start while frozen");
   a_irq_gated: assert property (irq |-> en_q != 2'h0)
      else $error("irq high with no source enabled");
   a_flag_w1c: assert property (s_clr_all |=> !irq)
      else $error("irq stays after clearing both flags");
   a_read_clears: assert property (s_res_read |=> !irq)
      else $error("irq stays after result read");
   a_byte_wide: assert property (avs_read && !avs_waitrequest |-> avs_readdata[31:8] == 24'h000000)
      else $error("read data above byte not zero");
endmodule // aic_regs_chk

bind aic_regs aic_regs_chk chk (.clk(clk), .srst(srst), .avs_address(avs_address), .avs_read(avs_read),
   .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
   .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .event_in(event_in),
   .cpu_halted(cpu_halted), .core_sample(core_sample), .core_start(core_start),
   .core_enable(core_enable), .irq(irq));

// File: test_aic_regs.sv
// self-checking bench for the converter register block
`timescale 1ns/10ps
module test_aic_regs
   import aic_pkg::*;
;
   logic clk = 1'b0;
   logic srst = 1'b1;
   logic [7:0] avs_address = 8'h00;
   logic avs_read = 1'b0;
   logic avs_write = 1'b0;
   logic [31:0] avs_writedata = 32'h00000000;
   logic [3:0] avs_byteenable = 4'hf;
   logic [31:0] avs_readdata;
   logic avs_waitrequest;
   logic event_in = 1'b0;
   logic cpu_halted = 1'b0;
   aic_sample_t core_sample = {1'b0, 12'h000};
   logic core_start;
   logic core_enable;
   logic irq;
   logic signed [11:0] raw_val = 12'h000;
   logic [7:0] rdv;
   int dly = 0;
   int err_total = 0;
   int tests_run = 0;
   always #50 clk = ~clk;
   aic_regs uut (.clk(clk), .srst(srst), .avs_address(avs_address), .avs_read(avs_read),
      .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
      .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .event_in(event_in),
      .cpu_halted(cpu_halted), .core_sample(core_sample), .core_start(core_start),
      .core_enable(core_enable), .irq(irq));
   // analog core stand-in: every sample reads raw_val a few cycles after its start
   always @(posedge clk) begin
      if (core_start === 1'b1) begin
         dly <= 4;
      end else if (dly > 0) begin
         dly <= dly - 1;
      end
      core_sample <= {dly == 1, raw_val};
   end
   task automatic bus(input logic wr, input logic [5:0] idx, input logic [7:0] wd);
      avs_address <= {idx, 2'h0};
      avs_writedata <= {24'h000000, wd};
      avs_write <= wr;
      avs_read <= !wr;
      @(posedge clk);
      // only the watchdog ends a wait that never finishes
      while (avs_waitrequest !== 1'b0) begin
         @(posedge clk);
      end
      rdv = avs_readdata[7:0];
      avs_write <= 1'b0;
      avs_read <= 1'b0;
      @(posedge clk);
   endtask
   task automatic check(input logic [15:0] got, input logic [15:0] exp);
      tests_run++;
      if (got !== exp) begin
         err_total++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic wr(input logic [5:0] idx, input logic [7:0] d);
      bus(1'b1, idx, d);
   endtask
   task automatic rd(input logic [5:0] idx, input logic [7:0] exp);
      bus(1'b0, idx, 8'h00);
      check({8'h00, rdv}, {8'h00, exp});
   endtask
   task automatic conv;
      int n;
      n = 0;
      wr(IDX_COMMAND, 8'h01);
      rd(IDX_COMMAND, 8'h01);
      while (rdv[0] !== 1'b0 && n < 400) begin
         bus(1'b0, IDX_COMMAND, 8'h00);
         n++;
      end
      check({15'h0000, rdv[0]}, 16'h0000);
   endtask
   // no completion signal exists for an ignored event, so a fixed span is waited
   task automatic ev;
      event_in <= 1'b1;
      @(posedge clk);
      event_in <= 1'b0;
      repeat (30) @(posedge clk);
   endtask
   task automatic t_reset;
      rd(IDX_IRQ_ENABLE, 8'h00);
      rd(IDX_IRQ_FLAGS, 8'h00);
      rd(IDX_STAGING, 8'h00);
      rd(IDX_RESULT_LO, 8'h00);
      rd(IDX_RESULT_HI, 8'h00);
      rd(6'h3f, 8'h00);
      $display("test reset done");
   endtask
   task automatic t_modes;
      logic [5:0] hit;
      hit = 6'h14;
      raw_val <= 12'h5dc;
      wr(IDX_IRQ_ENABLE, 8'h03);
      wr(IDX_LOWER_LO, 8'h00);
      wr(IDX_LOWER_HI, 8'h01);
      wr(IDX_UPPER_LO, 8'h00);
      wr(IDX_UPPER_HI, 8'h02);
      for (int m = 0; m < 6; m++) begin
         wr(IDX_WIN_MODE, 8'(m));
         conv();
         rd(IDX_IRQ_FLAGS, {6'h00, hit[m], 1'b1});
         check({15'h0000, irq}, 16'h0001);
         rd(IDX_RESULT_LO, 8'hff);
         rd(IDX_RESULT_HI, 8'h03);
         rd(IDX_IRQ_FLAGS, 8'h00);
      end
      $display("test window modes done");
   endtask
   task automatic t_accum;
      raw_val <= 12'h7d0;
      wr(IDX_ACCUM_CTRL, 8'h07);
      wr(IDX_WIN_MODE, 8'h03);
      wr(IDX_LOWER_LO, 8'h00);
      wr(IDX_LOWER_HI, 8'h00);
      wr(IDX_UPPER_LO, 8'hc0);
      wr(IDX_UPPER_HI, 8'hff);
      conv();
      rd(IDX_IRQ_FLAGS, 8'h01);
      wr(IDX_STAGING, 8'h5a);
      rd(IDX_STAGING, 8'h5a);
      rd(IDX_RESULT_LO, 8'hc0);
      rd(IDX_STAGING, 8'hff);
      rd(IDX_RESULT_HI, 8'hff);
      wr(IDX_RESULT_LO, 8'h12);
      rd(IDX_RESULT_LO, 8'hc0);
      wr(IDX_WIN_MODE, 8'h02);
      wr(IDX_UPPER_LO, 8'hbf);
      wr(IDX_UPPER_HI, 8'hff);
      conv();
      rd(IDX_IRQ_FLAGS, 8'h03);
      rd(IDX_RESULT_LO, 8'hc0);
      rd(IDX_IRQ_FLAGS, 8'h00);
      $display("test accumulation done");
   endtask
   task automatic t_clear;
      raw_val <= 12'hffb;
      wr(IDX_ACCUM_CTRL, 8'h00);
      wr(IDX_WIN_MODE, 8'h01);
      wr(IDX_LOWER_LO, 8'h01);
      wr(IDX_LOWER_HI, 8'h00);
      wr(IDX_IRQ_ENABLE, 8'h02);
      conv();
      rd(IDX_IRQ_FLAGS, 8'h03);
      check({15'h0000, irq}, 16'h0001);
      wr(IDX_IRQ_FLAGS, 8'h00);
      rd(IDX_IRQ_FLAGS, 8'h03);
      wr(IDX_IRQ_FLAGS, 8'h02);
      rd(IDX_IRQ_FLAGS, 8'h01);
      check({15'h0000, irq}, 16'h0000);
      wr(IDX_IRQ_ENABLE, 8'h01);
      check({15'h0000, irq}, 16'h0001);
      wr(IDX_IRQ_CLEAR, 8'h01);
      rd(IDX_IRQ_FLAGS, 8'h00);
      check({15'h0000, irq}, 16'h0000);
      rd(IDX_RESULT_LO, 8'h00);
      $display("test flag clearing done");
   endtask
   task automatic t_event;
      raw_val <= 12'h1a5;
      ev();
      rd(IDX_IRQ_FLAGS, 8'h00);
      wr(IDX_EVENT_CTRL, 8'h01);
      ev();
      rd(IDX_IRQ_FLAGS, 8'h01);
      wr(IDX_IRQ_CLEAR, 8'h03);
      cpu_halted <= 1'b1;
      ev();
      check({15'h0000, core_enable}, 16'h0000);
      rd(IDX_IRQ_FLAGS, 8'h00);
      wr(IDX_DEBUG_CTRL, 8'h01);
      ev();
      rd(IDX_IRQ_FLAGS, 8'h01);
      check({15'h0000, core_enable}, 16'h0001);
      cpu_halted <= 1'b0;
      rd(IDX_RESULT_LO, 8'ha5);
      rd(IDX_RESULT_HI, 8'h01);
      rd(IDX_IRQ_FLAGS, 8'h00);
      $display("test events and debug halt done");
   endtask
   task automatic summarize;
      $display("comparisons %0d, mismatches %0d", tests_run, err_total);
      if (err_total == 0 && tests_run > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask
   initial begin
      repeat (3) @(posedge clk);
      srst <= 1'b0;
      @(posedge clk);
      t_reset();
      t_modes();
      t_accum();
      t_clear();
      t_event();
      summarize();
   end
   initial begin
      repeat (30000) @(posedge clk);
      err_total++;
      summarize();
   end
endmodule // test_aic_regs
